// File: core/tql_pkg.sv
/*
 constants, register map and types of the trigger qualifier core.
 assumes a 20 MHz system clock and a plain word-wide register port.
*/
package tql_pkg;
    // clock and width resolution, in picoseconds
    localparam int unsigned CLK_PS       = 50000;
    localparam int unsigned STEP_PS      = 2500;
    localparam logic [32:0] STEP_PER_CLK = 33'(CLK_PS / STEP_PS);
    localparam logic [32:0] WCNT_SAT     = 33'h1_0000_0000;
    localparam logic [31:0] WREF_MIN     = 32'h0000_0001;
    // longest qualification time and largest event count
    localparam logic [63:0] TIME_MAX_PS  = 64'h0000_1230_CED6_4000;
    localparam logic [31:0] TIME_MAX_CYC = 32'(TIME_MAX_PS / 64'(CLK_PS));
    localparam logic [31:0] EVT_MAX      = 32'h3B9A_CA00;
    // register port widths
    localparam int          AW           = 4;
    localparam int          DW           = 32;
    // register indices
    localparam logic [3:0]  A_CTRL       = 4'h0;
    localparam logic [3:0]  A_PAT        = 4'h1;
    localparam logic [3:0]  A_WREF       = 4'h2;
    localparam logic [3:0]  A_HOLD       = 4'h3;
    localparam logic [3:0]  A_QUAL       = 4'h4;
    localparam logic [3:0]  A_LINE       = 4'h5;
    localparam logic [3:0]  A_TRACK      = 4'h6;
    localparam logic [3:0]  A_STAT       = 4'h7;
    localparam logic [3:0]  A_TCNT       = 4'h8;
    // control register field positions
    localparam int          F_MODE       = 0;
    localparam int          F_WCOND      = 3;
    localparam int          F_WINT       = 5;
    localparam int          F_FALL       = 6;
    localparam int          F_SRC        = 7;
    localparam int          F_EXIT       = 9;
    localparam int          F_HOLD       = 10;
    localparam int          F_QEVT       = 12;
    localparam int          F_VFLD       = 13;
    localparam int          F_VSUB       = 15;
    localparam int          CTRL_W       = 17;
    localparam logic [16:0] CTRL_RST     = 17'h0_0000;
    // track register field positions
    localparam int          F_NFLD       = 0;
    localparam int          F_ILACE      = 8;
    localparam int          F_LPP        = 12;
    // field codes
    localparam logic [1:0]  PT_LOW       = 2'h1;
    localparam logic [1:0]  PT_HIGH      = 2'h2;
    localparam logic [1:0]  WC_OFF       = 2'h0;
    localparam logic [1:0]  WC_LT        = 2'h1;
    localparam logic [1:0]  WC_GT        = 2'h2;
    localparam logic [1:0]  HO_NONE      = 2'h0;
    localparam logic [1:0]  HO_TIME      = 2'h1;
    localparam logic [1:0]  VF_ANY       = 2'h0;
    localparam logic [1:0]  VF_ODD       = 2'h1;
    localparam logic [1:0]  VF_EVEN      = 2'h2;
    localparam logic [1:0]  VS_ANY       = 2'h1;
    localparam logic [1:0]  VS_TRACK     = 2'h2;
    // trigger modes and video tracker states
    typedef enum logic [2:0] {M_SINGLE, M_PATTERN, M_SQUAL, M_TEQUAL, M_VIDEO} tql_mode_type;
    typedef enum logic [1:0] {V_IDLE, V_COUNT, V_LOCK} tql_vstate_type;
endpackage

// File: core/tql_core.sv
/*
 trigger qualifier core: turns comparator states and video detector
 pulses into a one-cycle acquisition trigger.
 assumes comparator and video inputs are asynchronous, arm and busy come
 from acquisition logic on clk, and software uses the plain register port.
*/
`timescale 1ns/100ps
// Behaviour
// - width reference in 2.5 ns steps, minimum one
// - narrow mode fires when width below reference
// - pattern is AND of three terms
// - each term requires low, high or ignores
// - pattern trigger on entering or exiting
// - width compare on pattern duration or interval
// - pattern mode keeps time or event hold-off
// - entering measures entry to entry interval
// - exiting measures duration, fires on fall
// - two-input state starts delay, gates third
// - state qualifier restarts on each entry
// - three-input state delay, then stays enabled
// - no restart until trigger or re-arm
// - video counts lines from chosen field start
// - field tracking re-triggers on known field
// - video any-line trigger without counting
// - counter spans 1e9 events or 20 s
// - hold-off started by accepted triggers, busy ignores
// - pulse to opposite edge, interval to same
module tql_core (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic [tql_pkg::AW-1:0] addr,
    input  wire logic [tql_pkg::DW-1:0] wdata,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    output logic      [tql_pkg::DW-1:0] rdata,
    input  wire logic [2:0]            comp_in,
    input  wire logic                  vid_field_start,
    input  wire logic                  vid_field_odd,
    input  wire logic                  vid_line_start,
    input  wire logic                  arm,
    input  wire logic                  acq_busy,
    output logic                       trig_out
);
    import tql_pkg::*;

    logic [CTRL_W-1:0] ctrl_r;      // mode and option bits
    logic [5:0]        pat_r;       // two bits per input
    logic [31:0]       wref_r;      // width reference, steps
    logic [31:0]       hold_r;      // hold-off, cycles or events
    logic [31:0]       qual_r;      // qualifier delay
    logic [11:0]       line_r;      // target line number
    logic [31:0]       track_r;     // field tracking settings
    logic [DW-1:0]     rdata_r;     // read data register
    logic [2:0]        comp_s1;     // synchroniser first stage
    logic [2:0]        comp_s2;     // synchronised comparators
    logic [2:0]        comp_d;      // previous synced state
    logic [2:0]        vid_s1;      // video first stage
    logic [2:0]        vid_s2;      // synced video pulses
    logic [2:0]        vid_d;       // previous video state
    logic              arm_d;       // previous arm level
    logic              pat_d;       // previous pattern value
    logic              sq_d;        // previous state qualifier
    tql_mode_type      mode_d;      // mode of the previous cycle
    logic [32:0]       wcnt_r;      // width counter, steps
    logic              wrun_r;      // width measurement open
    logic [31:0]       ho_cnt_r;    // hold-off remaining
    logic              ho_act_r;    // hold-off running
    logic [31:0]       qcnt_r;      // qualifier remaining
    logic              qrun_r;      // qualifier counting
    logic              qdone_r;     // qualifier satisfied
    tql_vstate_type    vstate_r;    // video tracker state
    logic [11:0]       lcnt_r;      // lines since field start
    logic [7:0]        fcnt_r;      // fields since lock
    logic              trig_r;      // trigger output register
    logic [15:0]       tcnt_r;      // issued trigger count

    // decoded control fields
    tql_mode_type mode;
    logic [1:0]   wcond;
    logic [1:0]   hkind;
    logic [1:0]   vfld;
    logic [1:0]   vsub;
    logic [1:0]   src;
    assign mode  = tql_mode_type'(ctrl_r[F_MODE +: 3]);
    assign wcond = ctrl_r[F_WCOND +: 2];
    assign hkind = ctrl_r[F_HOLD +: 2];
    assign vfld  = ctrl_r[F_VFLD +: 2];
    assign vsub  = ctrl_r[F_VSUB +: 2];
    assign src   = ctrl_r[F_SRC +: 2];

    // register writes; values clamped so counters stay in range
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_r  <= CTRL_RST;
            pat_r   <= 6'h00;
            wref_r  <= WREF_MIN;
            hold_r  <= 32'h0;
            qual_r  <= 32'h0;
            line_r  <= 12'h001;
            track_r <= 32'h0;
        end else if (wr_en) begin
            unique case (addr)
                A_CTRL:  ctrl_r  <= wdata[CTRL_W-1:0];
                A_PAT:   pat_r   <= wdata[5:0];
                // zero would mean no width at all
                A_WREF:  wref_r  <= (wdata < WREF_MIN) ? WREF_MIN : wdata;
                A_HOLD:  hold_r  <= (wdata > EVT_MAX) ? EVT_MAX : wdata;
                A_QUAL:  qual_r  <= (wdata > EVT_MAX) ? EVT_MAX : wdata;
                A_LINE:  line_r  <= wdata[11:0];
                A_TRACK: track_r <= wdata;
                default: ;
            endcase
        end
    end

    // status word built from live state
    logic [31:0] stat;
    assign stat = {23'h0, vstate_r == V_LOCK, vstate_r == V_COUNT, wrun_r,
                   qdone_r, ho_act_r, pat_d, comp_s2};

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!nrst || !rd_en) begin
            rdata_r <= '0;
        end else begin
            unique case (addr)
                A_CTRL:  rdata_r <= {15'h0, ctrl_r};
                A_PAT:   rdata_r <= {26'h0, pat_r};
                A_WREF:  rdata_r <= wref_r;
                A_HOLD:  rdata_r <= hold_r;
                A_QUAL:  rdata_r <= qual_r;
                A_LINE:  rdata_r <= {20'h0, line_r};
                A_TRACK: rdata_r <= track_r;
                A_STAT:  rdata_r <= stat;
                A_TCNT:  rdata_r <= {16'h0, tcnt_r};
                default: rdata_r <= '0; // unmapped reads zero
            endcase
        end
    end
    assign rdata = rdata_r;

    // two-stage synchronisers; only stage two is looked at
    always_ff @(posedge clk) begin
        if (!nrst) begin
            comp_s1 <= 3'h0;
            comp_s2 <= 3'h0;
            vid_s1  <= 3'h0;
            vid_s2  <= 3'h0;
        end else begin
            comp_s1 <= comp_in;
            comp_s2 <= comp_s1;
            vid_s1  <= {vid_line_start, vid_field_odd, vid_field_start};
            vid_s2  <= vid_s1;
        end
    end

    // per-input pattern terms; code 0 or 3 ignores the input
    logic [2:0] term_ok;
    for (genvar i = 0; i < 3; i++) begin : g_term
        assign term_ok[i] = (pat_r[2*i +: 2] == PT_LOW)  ? !comp_s2[i] :
                            (pat_r[2*i +: 2] == PT_HIGH) ?  comp_s2[i] : 1'b1;
    end

    logic       pat_now;   // all three terms hold
    logic       sq_now;    // two-input state, source ignored
    logic [2:0] src_hot;
    assign src_hot = 3'h1 << src;
    assign pat_now = &term_ok;
    assign sq_now  = &(term_ok | src_hot);

    // history for edge detection
    always_ff @(posedge clk) begin
        if (!nrst) begin
            comp_d <= 3'h0;
            vid_d  <= 3'h0;
            arm_d  <= 1'b0;
            pat_d  <= 1'b0;
            sq_d   <= 1'b0;
            mode_d <= M_SINGLE;
        end else begin
            comp_d <= comp_s2;
            vid_d  <= vid_s2;
            arm_d  <= arm;
            pat_d  <= pat_now;
            sq_d   <= sq_now;
            mode_d <= mode;
        end
    end

    // edges of the chosen source and the pattern
    logic s_now, s_old, slope_edge, opp_edge;
    logic pat_rise, pat_fall, sq_rise, arm_rise;
    logic fld_rise, line_rise, fld_odd;
    assign s_now      = comp_s2[src];
    assign s_old      = comp_d[src];
    assign slope_edge = ctrl_r[F_FALL] ? (s_old && !s_now) : (s_now && !s_old);
    assign opp_edge   = ctrl_r[F_FALL] ? (s_now && !s_old) : (s_old && !s_now);
    assign pat_rise   = pat_now && !pat_d;
    assign pat_fall   = !pat_now && pat_d;
    assign sq_rise    = sq_now && !sq_d;
    assign arm_rise   = arm && !arm_d;
    assign fld_rise   = vid_s2[0] && !vid_d[0];
    assign fld_odd    = vid_s2[1];
    assign line_rise  = vid_s2[2] && !vid_d[2];

    // measurement window edges and the point of the trigger
    logic m_start, m_end, m_evt;
    always_comb begin
        if (mode == M_PATTERN) begin
            m_start = pat_rise;
            m_end   = ctrl_r[F_EXIT] ? pat_fall : pat_rise;
            m_evt   = ctrl_r[F_EXIT] ? pat_fall : pat_rise;
        end else begin
            m_start = slope_edge;
            m_end   = ctrl_r[F_WINT] ? slope_edge : opp_edge;
            m_evt   = slope_edge;
        end
    end

    // width counter advances one clock period per cycle, in steps;
    // resolution is therefore one clock, not one step
    always_ff @(posedge clk) begin
        // an edge in the cycle of re-arming still opens its window
        if (!nrst || (arm_rise && !m_start)) begin
            wrun_r <= 1'b0;
            wcnt_r <= '0;
        end else if (m_start) begin
            wrun_r <= 1'b1; // interval restarts at its own end
            wcnt_r <= '0;
        end else if (m_end) begin
            wrun_r <= 1'b0; // duration closes at exit
        end else if (wrun_r && wcnt_r < WCNT_SAT) begin
            wcnt_r <= wcnt_r + STEP_PER_CLK;
        end
    end

    // width including the cycle of the closing edge
    logic [32:0] width_meas;
    logic        width_ok;
    assign width_meas = wcnt_r + STEP_PER_CLK;
    assign width_ok   = wrun_r && ((wcond == WC_LT) ? (width_meas < {1'b0, wref_r}) :
                                   (wcond == WC_GT) && (width_meas > {1'b0, wref_r}));

    // video: field and line matching
    logic        field_hit, line_hit, lost, vid_hit;
    logic [7:0]  nfld;
    logic [15:0] lines_x;
    assign nfld      = track_r[F_NFLD +: 8];
    assign lines_x   = {4'h0, lcnt_r} * {12'h0, track_r[F_ILACE +: 4]};
    assign lost      = lines_x > {4'h0, track_r[F_LPP +: 12]};
    assign field_hit = fld_rise && (vfld == VF_ANY || (vfld == VF_ODD && fld_odd) ||
                                    (vfld == VF_EVEN && !fld_odd));
    assign line_hit  = (vstate_r == V_COUNT) && line_rise && (lcnt_r + 12'h1 == line_r);
    assign vid_hit   = (vsub == VS_ANY) ? line_rise : line_hit;

    // potential trigger per mode
    logic pot, accept;
    always_comb begin
        pot = 1'b0;
        unique case (mode)
            M_SINGLE, M_PATTERN: pot = (wcond == WC_OFF) ? m_evt : (m_end && width_ok);
            M_SQUAL:  pot = slope_edge && sq_now && qdone_r;
            M_TEQUAL: pot = slope_edge && qdone_r;
            M_VIDEO:  pot = vid_hit;
            default:  pot = 1'b0; // illegal mode codes never fire
        endcase
    end
    // busy acquisition or running hold-off drops the candidate
    assign accept = pot && arm && !acq_busy && !ho_act_r;

    // hold-off loads on each accepted trigger, by time or events,
    // in every mode alike
    logic [31:0] hold_ld;
    assign hold_ld = (hkind == HO_TIME && hold_r > TIME_MAX_CYC) ? TIME_MAX_CYC : hold_r;
    always_ff @(posedge clk) begin
        // a trigger in the cycle of re-arming still starts its hold-off
        if (!nrst || (arm_rise && !accept)) begin
            ho_act_r <= 1'b0;
            ho_cnt_r <= 32'h0;
        end else if (accept) begin
            ho_act_r <= (hkind != HO_NONE) && (hold_ld != 32'h0);
            ho_cnt_r <= hold_ld;
        end else if (ho_act_r && (hkind == HO_TIME || pot)) begin
            // event hold-off counts the ignored candidates
            ho_cnt_r <= ho_cnt_r - 32'h1;
            if (ho_cnt_r == 32'h1) begin
                ho_act_r <= 1'b0;
            end
        end
    end

    // qualifier delay shared by both qualified modes
    logic        q_start, q_tick, q_clr;
    logic [31:0] qual_ld;
    assign qual_ld = (!ctrl_r[F_QEVT] && qual_r > TIME_MAX_CYC) ? TIME_MAX_CYC : qual_r;
    assign q_start = (mode == M_SQUAL) ? sq_rise :
                     (mode == M_TEQUAL) && pat_rise && !qrun_r && !qdone_r;
    assign q_tick  = ctrl_r[F_QEVT] ? slope_edge : 1'b1;
    // a mode change drops qualification left over from the other qualified mode
    assign q_clr   = arm_rise || (mode == M_TEQUAL && accept) || (mode != mode_d) ||
                     (mode == M_SQUAL && !sq_now) || (mode != M_SQUAL && mode != M_TEQUAL);
    always_ff @(posedge clk) begin
        // a new state entry wins over a clear in the same cycle
        if (!nrst || (q_clr && !q_start)) begin
            qrun_r  <= 1'b0;
            qdone_r <= 1'b0;
            qcnt_r  <= 32'h0;
        end else if (q_start) begin
            qcnt_r  <= qual_ld;
            qrun_r  <= qual_ld != 32'h0;
            qdone_r <= qual_ld == 32'h0;
        end else if (qrun_r && q_tick) begin
            qcnt_r <= qcnt_r - 32'h1;
            if (qcnt_r == 32'h1) begin
                qrun_r  <= 1'b0;
                qdone_r <= 1'b1; // stays until re-arm, mode change, trigger (M_TEQUAL) or state exit (M_SQUAL)
            end
        end
    end

    // line and field counters of the video tracker
    always_ff @(posedge clk) begin
        if (!nrst || fld_rise) begin
            lcnt_r <= 12'h0;
        end else if (line_rise && lcnt_r != 12'hFFF) begin
            lcnt_r <= lcnt_r + 12'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst || line_hit) begin
            fcnt_r <= 8'h0;
        end else if (vstate_r == V_LOCK && fld_rise) begin
            fcnt_r <= fcnt_r + 8'h1;
        end
    end

    // video tracker: wait for field, count lines, then hold lock
    always_ff @(posedge clk) begin
        if (!nrst || arm_rise || mode != M_VIDEO || vsub == VS_ANY) begin
            vstate_r <= V_IDLE;
        end else begin
            unique case (vstate_r)
                V_IDLE: begin
                    if (field_hit) begin
                        vstate_r <= V_COUNT;
                    end
                end
                V_COUNT: begin
                    if (line_hit) begin
                        vstate_r <= (vsub == VS_TRACK) ? V_LOCK : V_IDLE;
                    end else if (fld_rise && !field_hit) begin
                        vstate_r <= V_IDLE; // target line missed
                    end
                end
                V_LOCK: begin
                    // field count relative to the latest target line hit
                    if (fld_rise && fcnt_r + 8'h1 >= nfld) begin
                        vstate_r <= V_COUNT;
                    end else if (lost) begin
                        vstate_r <= V_IDLE; // more lines than a field holds
                    end
                end
            endcase
        end
    end

    // trigger output and issued count
    always_ff @(posedge clk) begin
        if (!nrst) begin
            trig_r <= 1'b0;
            tcnt_r <= 16'h0;
        end else begin
            trig_r <= accept;
            if (accept) begin
                tcnt_r <= tcnt_r + 16'h1;
            end
        end
    end
    assign trig_out = trig_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_wref_min;
        wref_r >= WREF_MIN;
    endproperty
    a_wref_min: assert property (p_wref_min) else $error("width reference below one step");
    property p_narrow;
        accept && mode == M_SINGLE && wcond == WC_LT |-> width_meas < {1'b0, wref_r};
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow trigger on wide pulse");
    property p_and;
        pat_now |-> (pat_r[1:0] != PT_HIGH || comp_s2[0]) && (pat_r[3:2] != PT_LOW || !comp_s2[1]);
    endproperty
    a_and: assert property (p_and) else $error("pattern true with term unmet");
    property p_exit;
        accept && mode == M_PATTERN && ctrl_r[F_EXIT] |-> pat_d && !pat_now;
    endproperty
    a_exit: assert property (p_exit) else $error("exit trigger without pattern fall");
    property p_sq_hold;
        accept && mode == M_SQUAL |-> sq_now && qdone_r;
    endproperty
    a_sq_hold: assert property (p_sq_hold) else $error("state trigger without state");
    property p_sq_restart;
        mode == M_SQUAL && sq_rise && qual_r != 32'h0 |=> !qdone_r && qrun_r;
    endproperty
    a_sq_restart: assert property (p_sq_restart) else $error("qualifier not restarted");
    property p_te_keep;
        qdone_r && mode == M_TEQUAL && !accept && !arm_rise ##1 mode == M_TEQUAL |-> qdone_r;
    endproperty
    a_te_keep: assert property (p_te_keep) else $error("qualification lost early");
    property p_busy;
        trig_out |-> $past(arm) && !$past(acq_busy) && !$past(ho_act_r);
    endproperty
    a_busy: assert property (p_busy) else $error("trigger while busy or held off");
    property p_any_line;
        mode == M_VIDEO && vsub == VS_ANY && line_rise && arm && !acq_busy && !ho_act_r |=> trig_out;
    endproperty
    a_any_line: assert property (p_any_line) else $error("any-line trigger missed");
    property p_hold_time;
        accept && hkind == HO_TIME && hold_r == 32'h2 |=> ho_act_r ##1 ho_act_r ##1 !ho_act_r;
    endproperty
    a_hold_time: assert property (p_hold_time) else $error("time hold-off length wrong");

    c_pattern: cover property (accept && mode == M_PATTERN && wcond != WC_OFF);
    c_teq: cover property (accept && mode == M_TEQUAL);
    c_lock: cover property (vstate_r == V_LOCK ##[1:1000] accept);
endmodule

// File: dv/tql_front_model.sv
/*
 comparator front model: turns levels commanded by the bench into the three
 comparator outputs that feed the trigger qualifier.
 assumes the bench changes lvl just after a rising clk edge.
*/
`timescale 1ns/100ps
module tql_front_model (
    input  wire logic       clk,
    input  wire logic [2:0] lvl,
    input  wire logic       slow,
    output logic      [2:0] comp_in
);
    logic [2:0] lag_r; // one extra stage of comparator delay
    // slow mode models a sluggish comparator; only switch it while lvl is still
    always_ff @(posedge clk) begin
        lag_r <= lvl;
    end
    assign comp_in = slow ? lag_r : lvl;
endmodule

// File: dv/tql_core_test.sv
/*
 self-checking bench of the trigger qualifier core: register port, single,
 narrow-pulse, pattern and video triggers, busy and disarm refusal.
 assumes the 20 MHz clock and the register map of the core package.
*/
`timescale 1ns/100ps
module tql_core_test;
    import tql_pkg::*;
    logic clk, nrst, wr_en, rd_en, arm, acq_busy, slow, trig_out;
    logic vid_field_start, vid_field_odd, vid_line_start;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata;
    logic [2:0] lvl, comp_in;
    logic [7:0] lfsr_r = 8'h48; // fixed seed keeps runs repeatable
    int err_count = 0, n_compared = 0, n_trig = 0, base = 0, cyc = 0, expn;
    bit prev_m;

    tql_front_model front (.clk(clk), .lvl(lvl), .slow(slow), .comp_in(comp_in));
    tql_core uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .comp_in(comp_in), .vid_field_start(vid_field_start), .vid_field_odd(vid_field_odd),
        .vid_line_start(vid_line_start), .arm(arm), .acq_busy(acq_busy), .trig_out(trig_out));

    always #25 clk = ~clk;
    // count issued triggers; the design holds trig_out for one cycle only
    always @(posedge clk) begin
        // an unknown trigger counts, so it cannot hide behind an expected zero
        if (trig_out !== 1'b0) n_trig <= n_trig + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // next random byte of the bench generator
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    // pattern 0x09: input 0 low, input 1 high, input 2 ignored
    function automatic bit pat_hit(input logic [2:0] v);
        return (v[0] == 1'b0) && (v[1] == 1'b1);
    endfunction
    task automatic chk(input int got, input int exp, input string msg);
        n_compared++;
        if (got != exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %0d expected %0d", $time, msg, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a; rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        n_compared++;
        if (rdata !== exp) begin
            err_count++;
            $display("wrong value at %0t: reg %0h got %0h", $time, a, rdata);
        end
    endtask
    // high pulse of w cycles on input 0, then settle and return triggers seen
    task automatic pulse(input int w, output int got);
        base = n_trig;
        lvl <= 3'b001; step(w);
        lvl <= 3'b000; step(10);
        got = n_trig - base;
    endtask
    // drive the comparator levels and keep them for n cycles
    task automatic hold_lvl(input logic [2:0] v, input int n);
        lvl <= v;
        step(n);
    endtask
    // one field start (odd level beside it) or one line start, then a gap
    task automatic vid_pulse(input bit fld, input bit odd);
        vid_field_odd <= odd;
        if (fld) vid_field_start <= 1'b1;
        else vid_line_start <= 1'b1;
        step(2);
        vid_field_start <= 1'b0;
        vid_line_start <= 1'b0;
        step(4);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        int got;
        clk = 0; nrst = 0; addr = '0; wdata = '0; wr_en = 0; rd_en = 0; lvl = 0; slow = 0;
        arm = 0; acq_busy = 0; vid_field_start = 0; vid_field_odd = 0; vid_line_start = 0;
        step(16);
        nrst <= 1'b1;
        rd(A_WREF, 32'h1);
        rd(A_CTRL, 32'h0);
        rd(4'hC, 32'h0); // unmapped place reads zero
        wr(A_WREF, 32'h0); rd(A_WREF, 32'h1);
        $display("test registers done");
        arm <= 1'b1;
        wr(A_CTRL, 32'h0); pulse(3, got); chk(got, 1, "single edge");
        acq_busy <= 1'b1; pulse(3, got); chk(got, 0, "busy refusal");
        acq_busy <= 1'b0; arm <= 1'b0; pulse(3, got); chk(got, 0, "disarmed");
        arm <= 1'b1;
        $display("test single done");
        // 40 steps = two clock periods: one period passes, two sit on the boundary
        wr(A_WREF, 32'd40); wr(A_CTRL, 32'h8);
        pulse(1, got); chk(got, 1, "narrow fires");
        slow <= 1'b1; pulse(2, got); chk(got, 0, "equal width");
        slow <= 1'b0; pulse(4, got); chk(got, 0, "wide pulse");
        $display("test narrow done");
        wr(A_PAT, 32'h09); wr(A_CTRL, 32'h1);
        base = n_trig; expn = 0; prev_m = 0;
        // random levels, each held long enough to pass the synchronisers
        for (int i = 0; i < 24; i++) begin
            lfsr_r = lfsr(lfsr_r);
            if (pat_hit(lfsr_r[2:0]) && !prev_m) expn++;
            prev_m = pat_hit(lfsr_r[2:0]);
            lvl <= lfsr_r[2:0]; step(6);
        end
        lvl <= 3'b000; step(8);
        chk(n_trig - base, expn, "pattern entries");
        wr(A_CTRL, 32'h201); base = n_trig;
        lvl <= 3'b110; step(8); lvl <= 3'b000; step(8);
        chk(n_trig - base, 1, "pattern exit");
        $display("test pattern done");
        wr(A_CTRL, 32'h8004); base = n_trig;
        repeat (3) vid_pulse(1'b0, 1'b0);
        chk(n_trig - base, 3, "any line");
        // line three of any field fires, the fourth line stays quiet
        wr(A_LINE, 32'd3);
        wr(A_CTRL, 32'h4);
        base = n_trig;
        vid_pulse(1'b1, 1'b0);
        repeat (4) vid_pulse(1'b0, 1'b0);
        chk(n_trig - base, 1, "line count");
        // odd fields only, yet tracking fires again on the following field
        wr(A_LINE, 32'd1);
        wr(A_CTRL, 32'h12004);
        base = n_trig;
        vid_pulse(1'b1, 1'b1);
        vid_pulse(1'b0, 1'b1);
        vid_pulse(1'b1, 1'b0);
        vid_pulse(1'b0, 1'b0);
        chk(n_trig - base, 2, "field tracking");
        $display("test video done");
        // state qualified on inputs 0 and 1, source input 2, delay 5 cycles
        wr(A_QUAL, 32'd5);
        wr(A_CTRL, 32'h102);
        base = n_trig;
        hold_lvl(3'b010, 10);
        hold_lvl(3'b110, 3);
        hold_lvl(3'b010, 8);
        chk(n_trig - base, 1, "state qualified");
        hold_lvl(3'b000, 4);
        hold_lvl(3'b010, 3);
        hold_lvl(3'b110, 3);
        hold_lvl(3'b000, 8);
        chk(n_trig - base, 1, "state restart");
        // time qualified, delay 12: re-entry must not restart, state may be gone
        wr(A_QUAL, 32'd12);
        wr(A_CTRL, 32'h103);
        base = n_trig;
        hold_lvl(3'b010, 3);
        hold_lvl(3'b000, 3);
        hold_lvl(3'b010, 3);
        hold_lvl(3'b000, 6);
        hold_lvl(3'b100, 3);
        hold_lvl(3'b000, 8);
        chk(n_trig - base, 1, "late qualified");
        $display("test qualify done");
        // time hold-off on single edges of input 0
        wr(A_HOLD, 32'd2);
        wr(A_CTRL, 32'h400);
        pulse(3, got);
        chk(got, 1, "short hold");
        wr(A_HOLD, 32'd30);
        pulse(3, got);
        chk(got, 1, "hold first");
        pulse(3, got);
        chk(got, 0, "held off");
        step(20);
        pulse(3, got);
        chk(got, 1, "hold over");
        $display("test holdoff done");
        stop_test();
    end
endmodule
